/* File: hw/opd_divider.sv */
// Output pair divider channel: registers, phase counting, sync and routing.
// Assumes mclk oversamples the clock levels; div_in_tick marks input cycles.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module opd_divider
   import opd_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [DATA_W-1:0] rdata,
   input wire logic div_in_tick,
   input wire logic dist_clk_lvl,
   input wire logic vco_clk_lvl,
   input wire logic ext_clk_lvl,
   input wire logic [1:0] src_sel,
   input wire logic chip_align,
   output logic pair_output_a,
   output logic pair_output_b
);
   logic [DATA_W-1:0] period_q;
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] route_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] status_w;
   opd_state_t state_q;
   opd_state_t state_d;
   logic lvl_q;
   logic lvl_d;
   logic pair_q;
   logic pair_d;

   // Address decode for the register port
   logic we_period;
   logic we_ctrl;
   logic we_route;
   logic [DATA_W-1:0] route_wdata;
   assign we_period = wr_stb && (addr == ADDR_PERIOD);
   assign we_ctrl = wr_stb && (addr == ADDR_CTRL);
   assign we_route = wr_stb && (addr == ADDR_ROUTE);
   assign route_wdata = wdata & ROUTE_MASK;

   opd_reg8 #(
      .RST(RST_PERIOD)
   ) u_period (
      .mclk(mclk),
      .reset_n(reset_n),
      .we(we_period),
      .wdata(wdata),
      .q(period_q)
   );

   opd_reg8 #(
      .RST(RST_CTRL)
   ) u_ctrl (
      .mclk(mclk),
      .reset_n(reset_n),
      .we(we_ctrl),
      .wdata(wdata),
      .q(ctrl_q)
   );

   opd_reg8 #(
      .RST(RST_ROUTE)
   ) u_route (
      .mclk(mclk),
      .reset_n(reset_n),
      .we(we_route),
      .wdata(route_wdata),
      .q(route_q)
   );

   // Control and routing fields
   logic bypass;
   logic nosync;
   logic force_high;
   logic start_high;
   logic [3:0] phase_ofs;
   logic direct;
   logic duty_fix_disable;
   assign bypass = ctrl_q[CTL_BYPASS];
   assign nosync = ctrl_q[CTL_NOSYNC];
   assign force_high = ctrl_q[CTL_FORCE];
   assign start_high = ctrl_q[CTL_START];
   assign phase_ofs = ctrl_q[CTL_OFS_MSB:CTL_OFS_LSB];
   assign direct = route_q[RTE_DIRECT];
   assign duty_fix_disable = route_q[RTE_DCC_OFF];

   // Phase lengths; a field value n lasts n+1 input cycles
   // A zero field still gives a one-cycle phase, so the counter never stalls
   logic [CNT_W-1:0] raw_lo;
   logic [CNT_W-1:0] raw_hi;
   assign raw_lo = {1'b0, period_q[PER_LO_MSB:PER_LO_LSB]} + CNT_ONE;
   assign raw_hi = {1'b0, period_q[PER_HI_MSB:PER_HI_LSB]} + CNT_ONE;

   // Correction splits the whole period evenly; odd totals favour low
   // Trade-off: costs an adder but needs no second edge of the input clock
   logic [SUM_W-1:0] period_sum;
   logic [SUM_W-1:0] fix_hi_w;
   logic [SUM_W-1:0] fix_lo_w;
   logic [CNT_W-1:0] hi_len;
   logic [CNT_W-1:0] lo_len;
   assign period_sum = {1'b0, raw_lo} + {1'b0, raw_hi};
   assign fix_hi_w = period_sum >> 1;
   assign fix_lo_w = period_sum - fix_hi_w;
   assign hi_len = duty_fix_disable ? raw_hi : fix_hi_w[CNT_W-1:0];
   assign lo_len = duty_fix_disable ? raw_lo : fix_lo_w[CNT_W-1:0];

   // Alignment only reaches a divider that obeys it
   logic align_hit;
   assign align_hit = chip_align && !nosync;

   // Forced level needs sync ignored, otherwise it is inert
   logic force_eff;
   assign force_eff = force_high && nosync;

   // A running phase counter reaching one on a tick toggles the level
   logic [CNT_W-1:0] ph_cnt;
   logic ph_zero;
   logic ph_load;
   logic [CNT_W-1:0] ph_val;
   logic toggle;
   assign toggle = (state_q == ST_RUN) && div_in_tick && (ph_cnt == CNT_ONE);

   // Offset counter delays the first toggle after release
   logic [CNT_W-1:0] ofs_cnt;
   logic ofs_zero;
   logic ofs_load;
   logic [CNT_W-1:0] ofs_val;
   assign ofs_val = {1'b0, phase_ofs};

   opd_down_cnt #(
      .W(CNT_W)
   ) u_phase (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(ph_load),
      .load_val(ph_val),
      .tick(div_in_tick),
      .cnt_q(ph_cnt),
      .zero(ph_zero)
   );

   opd_down_cnt #(
      .W(CNT_W)
   ) u_offset (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(ofs_load),
      .load_val(ofs_val),
      .tick(div_in_tick),
      .cnt_q(ofs_cnt),
      .zero(ofs_zero)
   );

   // Sequencer: hold at start level, wait offset, then alternate phases
   // Alignment is a level; a long pulse keeps an obeying divider parked
   always_comb begin
      state_d = state_q;
      lvl_d = lvl_q;
      ph_load = 1'b0;
      ph_val = lo_len;
      ofs_load = 1'b0;
      unique case (state_q)
         ST_HOLD: begin
            lvl_d = start_high;
            if (!bypass && !align_hit) begin
               state_d = ST_OFFSET;
               ofs_load = 1'b1;
            end
         end
         ST_OFFSET: begin
            if (ofs_zero) begin
               state_d = ST_RUN;
               ph_load = 1'b1;
               ph_val = lvl_q ? hi_len : lo_len;
            end
         end
         ST_RUN: begin
            if (toggle) begin
               lvl_d = !lvl_q;
               ph_load = 1'b1;
               ph_val = lvl_q ? lo_len : hi_len;
            end
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
      // Alignment or bypass drops back to hold and reloads later
      if (align_hit || bypass) begin
         state_d = ST_HOLD;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_HOLD;
         lvl_q <= 1'b0;
      end else begin
         state_q <= state_d;
         lvl_q <= lvl_d;
      end
   end

   // Divider-side level: bypass, forced level, or counted phases
   logic div_lvl;
   assign div_lvl = bypass ? dist_clk_lvl : force_eff ? 1'b1 : lvl_q;

   // Direct routing; illegal source codes leave the divider in place
   logic src_bad;
   logic take_vco;
   logic take_ext;
   assign src_bad = (src_sel == SRC_BAD);
   assign take_vco = direct && (src_sel == SRC_VCO);
   assign take_ext = direct && (src_sel == SRC_EXT);
   assign pair_d = take_vco ? vco_clk_lvl : take_ext ? ext_clk_lvl : div_lvl;

   // Both outputs of the pair share one flop to keep them skew free
   // One cycle of latency is the price of glitch-free routing changes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pair_q <= 1'b0;
      end else begin
         pair_q <= pair_d;
      end
   end
   assign pair_output_a = pair_q;
   assign pair_output_b = pair_q;

   // Status and read mux; unmapped reads give zero
   assign status_w = {4'h0, src_bad, (state_q == ST_HOLD), (state_q == ST_RUN), lvl_q};
   assign rdata_d = !rd_stb ? RDATA_IDLE :
                    (addr == ADDR_PERIOD) ? period_q :
                    (addr == ADDR_CTRL) ? ctrl_q :
                    (addr == ADDR_ROUTE) ? route_q :
                    (addr == ADDR_STATUS) ? status_w : RDATA_IDLE;

   // Read data live only in the cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= RDATA_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign rdata = rdata_q;

   // Checks on the channel behaviour
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   low_phase_a: assert property (
      (toggle && !lvl_q) |=> (lvl_q && ph_cnt == $past(hi_len)))
      else $error("low phase did not end into high length");

   high_phase_a: assert property (
      (toggle && lvl_q) |=> (!lvl_q && ph_cnt == $past(lo_len)))
      else $error("high phase did not end into low length");

   bypass_pass_a: assert property (
      (bypass && !direct && $stable(ctrl_q)) |=> (pair_q == $past(dist_clk_lvl)
         && state_q == ST_HOLD))
      else $error("bypass did not pass the input clock");

   align_hold_a: assert property (
      align_hit |=> (state_q == ST_HOLD))
      else $error("obeyed alignment did not hold divider");

   nosync_run_a: assert property (
      (state_q == ST_RUN && nosync && !bypass && $stable(ctrl_q)) |=> (state_q == ST_RUN))
      else $error("ignored alignment still stopped divider");

   force_high_a: assert property (
      (force_eff && !bypass && !direct) |=> pair_q)
      else $error("forced level not high");

   start_level_a: assert property (
      (state_q == ST_HOLD) |=> (lvl_q == $past(start_high)))
      else $error("held level differs from start level");

   route_div_a: assert property (
      !direct |=> (pair_q == $past(div_lvl)))
      else $error("pair not driven from divider");

   route_vco_a: assert property (
      (direct && src_sel == SRC_VCO) |=> (pair_q == $past(vco_clk_lvl)))
      else $error("VCO not routed to pair");

   route_ext_a: assert property (
      (direct && src_sel == SRC_EXT) |=> (pair_q == $past(ext_clk_lvl)))
      else $error("external clock not routed to pair");

   route_none_a: assert property (
      (direct && (src_sel == SRC_NONE || src_sel == SRC_BAD)) |=>
         (pair_q == $past(div_lvl)))
      else $error("inert source code changed routing");

   duty_fix_a: assert property (
      (!duty_fix_disable && toggle && !lvl_q) |=>
         (ph_cnt == $past(period_sum[SUM_W-1:1])))
      else $error("corrected high phase is not half period");

   offset_wait_a: assert property (
      (state_q == ST_OFFSET && !ofs_zero && !align_hit && !bypass) |=>
         (state_q == ST_OFFSET))
      else $error("offset wait ended early");

   restart_load_a: assert property (
      (state_q == ST_HOLD && !bypass && !align_hit) |=>
         (state_q == ST_OFFSET && ofs_cnt == $past(ofs_val)))
      else $error("release did not reload offset");

   read_one_a: assert property (
      (!rd_stb) |=> (rdata == RDATA_IDLE))
      else $error("read data outside answer cycle");

   // A running counter is reloaded at one, so zero means a lost reload
   phase_live_a: assert property (
      (state_q == ST_RUN) |-> !ph_zero)
      else $error("phase counter empty while running");

   level_steady_a: assert property (
      (state_q == ST_RUN && !toggle) |=> (lvl_q == $past(lvl_q)))
      else $error("level moved inside a phase");

   offset_exit_a: assert property (
      (state_q == ST_OFFSET && ofs_zero && !align_hit && !bypass) |=>
         (state_q == ST_RUN && lvl_q == $past(lvl_q)))
      else $error("offset end did not start the phases");

   // Main scenarios the bench is expected to reach
   run_seen_c: cover property (state_q == ST_HOLD ##1 state_q == ST_OFFSET ##[1:40]
      state_q == ST_RUN);
   toggle_seen_c: cover property (toggle ##[1:40] toggle);
   align_restart_c: cover property (state_q == ST_RUN ##1 state_q == ST_HOLD);
   direct_vco_c: cover property (take_vco && vco_clk_lvl);
   force_seen_c: cover property (force_eff ##1 pair_q);
endmodule
`default_nettype wire

/* File: hw/opd_pkg.sv */
// Constants, field positions and state codes for the output pair divider.
// Assumes one clock domain and the plain register port of the top module.
// How it works
// - Output stays low for the count in the period register upper nibble.
// - Output stays high for the count in the period register lower nibble.
// - Control bit 7 set bypasses the divider and passes its input clock.
// - Control bit 6 clear obeys chip alignment; set ignores it.
// - Control bit 5 forces a static high level, only with sync ignored.
// - Control bit 4 picks the level the divider starts with.
// - Routing bit 1 clear drives both pair outputs from this divider.
// - Routing bit 1 set takes VCO on 10b, external clock on 00b, 01b nothing.
// - Routing bit 0 clear enables duty-cycle correction; set disables it.
// - Source bit 1 picks VCO or external clock; VCO forbids divider bypass.
// - Source bit 0 bypasses VCO divider; VCO must not be chosen then.
package opd_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int CNT_W = 5;
   localparam int SUM_W = 6;

   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_PERIOD = 9'h196;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 9'h197;
   localparam logic [ADDR_W-1:0] ADDR_ROUTE = 9'h198;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 9'h199;

   // Reset values and the routing write mask
   localparam logic [DATA_W-1:0] RST_PERIOD = 8'h00;
   localparam logic [DATA_W-1:0] RST_CTRL = 8'h00;
   localparam logic [DATA_W-1:0] RST_ROUTE = 8'h00;
   localparam logic [DATA_W-1:0] ROUTE_MASK = 8'h03;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

   // Period register fields
   localparam int PER_LO_MSB = 7;
   localparam int PER_LO_LSB = 4;
   localparam int PER_HI_MSB = 3;
   localparam int PER_HI_LSB = 0;

   // Control register fields
   localparam int CTL_BYPASS = 7;
   localparam int CTL_NOSYNC = 6;
   localparam int CTL_FORCE = 5;
   localparam int CTL_START = 4;
   localparam int CTL_OFS_MSB = 3;
   localparam int CTL_OFS_LSB = 0;

   // Routing register fields
   localparam int RTE_DIRECT = 1;
   localparam int RTE_DCC_OFF = 0;

   // Status register fields
   localparam int STS_LEVEL = 0;
   localparam int STS_RUN = 1;
   localparam int STS_HOLD = 2;
   localparam int STS_SRC_BAD = 3;

   // Source select codes
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_NONE = 2'h1;
   localparam logic [1:0] SRC_VCO = 2'h2;
   localparam logic [1:0] SRC_BAD = 2'h3;

   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_OFFSET = 2'b01,
      ST_RUN = 2'b10
   } opd_state_t;
endpackage

/* File: hw/opd_reg8.sv */
// One software register of the divider, loaded by a write strobe.
// Assumes the caller decodes the address and masks unused bits.
`timescale 1ns/1ps
`default_nettype none
module opd_reg8 #(
   parameter logic [7:0] RST = 8'h00
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);
   // Plain storage; reset value set per instance
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q <= RST;
      end else if (we) begin
         q <= wdata;
      end
   end
endmodule
`default_nettype wire

/* File: hw/opd_down_cnt.sv */
// Down counter stepped by the divider input tick, with priority load.
// Assumes tick is a one-cycle pulse per divider input clock cycle.
`timescale 1ns/1ps
`default_nettype none
module opd_down_cnt #(
   parameter int W = 5
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   output logic [W-1:0] cnt_q,
   output logic zero
);
   logic [W-1:0] cnt_d;

   // Load beats tick so a reload never loses a step
   assign cnt_d = load ? load_val : (tick && (cnt_q != '0)) ? cnt_q - 1'b1 : cnt_q;
   assign zero = (cnt_q == '0);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb_output_pair_divider.sv */
// Self-checking bench for the output pair divider channel.
// Assumes the package and design modules under hw/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
   num_checks++; \
   if ((got) !== (ex)) begin \
      n_errors++; \
      $display("Error %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module tb_output_pair_divider;
   import opd_pkg::*;
   logic mclk, reset_n, wr_stb, rd_stb, tick, dist_lvl, vco_lvl, ext_lvl, chip_align;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   wire logic [DATA_W-1:0] rdata;
   logic [1:0] src_sel;
   logic slow = 1'b0;
   wire logic pair_output_a, pair_output_b;
   int n_errors = 0;
   int num_checks = 0;

   opd_divider u_dut (
      .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .div_in_tick(tick),
      .dist_clk_lvl(dist_lvl), .vco_clk_lvl(vco_lvl), .ext_clk_lvl(ext_lvl),
      .src_sel(src_sel), .chip_align(chip_align),
      .pair_output_a(pair_output_a), .pair_output_b(pair_output_b)
   );

   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Divider input ticks: every cycle, or every other cycle when slow
   always @(posedge mclk) begin
      tick <= slow ? !tick : 1'b1;
   end

   task automatic close_out;
      $display("Checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Register port cycles; the slave never stalls
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 `CHK("rdata", ex, rdata)
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Cycles until the output changes, capped so a stuck output cannot hang us
   task automatic edge_wait(output int n);
      logic v;
      n = 0;
      #1;
      v = pair_output_a;
      while (pair_output_a === v && n < 300) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK("pair_b", pair_output_a, pair_output_b)
   endtask

   task automatic lvl_chk(input logic ex);
      settle(4);
      `CHK("pair_a", ex, pair_output_a)
   endtask

   task automatic setup(input logic [7:0] per, input logic [7:0] ctl, input logic [7:0] rte);
      @(posedge mclk);
      chip_align <= 1'b1;
      wr(ADDR_PERIOD, per);
      wr(ADDR_ROUTE, rte);
      wr(ADDR_CTRL, ctl);
   endtask

   task automatic t_regs;
      rd_chk(ADDR_PERIOD, RST_PERIOD);
      rd_chk(ADDR_CTRL, RST_CTRL);
      rd_chk(ADDR_ROUTE, RST_ROUTE);
      wr(ADDR_PERIOD, 8'hA5);
      wr(ADDR_CTRL, 8'h5A);
      wr(ADDR_ROUTE, 8'hFF);
      wr(9'h1A0, 8'h77);
      rd_chk(ADDR_PERIOD, 8'hA5);
      rd_chk(ADDR_CTRL, 8'h5A);
      rd_chk(ADDR_ROUTE, 8'h03);
      rd_chk(9'h1A0, 8'h00);
   endtask

   // Period fields hold n+1 input cycles; measured on the first full cycle
   task automatic t_period(input logic [7:0] rte, input int ex_hi, input int ex_lo);
      int n, h, l;
      setup(8'h12, 8'h00, rte);
      lvl_chk(1'b0);
      @(posedge mclk);
      chip_align <= 1'b0;
      edge_wait(n);
      edge_wait(h);
      edge_wait(l);
      `CHK("high_len", ex_hi, h)
      `CHK("low_len", ex_lo, l)
   endtask

   // Ticks on every other cycle double every phase in clock cycles
   task automatic t_slow;
      int n, h, l;
      setup(8'h12, 8'h00, 8'h01);
      slow <= 1'b1;
      lvl_chk(1'b0);
      @(posedge mclk);
      chip_align <= 1'b0;
      edge_wait(n);
      edge_wait(h);
      edge_wait(l);
      slow <= 1'b0;
      `CHK("slow_high", 6, h)
      `CHK("slow_low", 4, l)
   endtask

   task automatic t_sync;
      int n;
      setup(8'h12, 8'h10, 8'h01);
      lvl_chk(1'b1);
      wr(ADDR_CTRL, 8'h00);
      lvl_chk(1'b0);
      wr(ADDR_CTRL, 8'h40);
      edge_wait(n);
      `CHK("runs_unsynced", 1'b1, n < 40)
   endtask

   task automatic t_force;
      int n;
      setup(8'h12, 8'h60, 8'h01);
      lvl_chk(1'b1);
      edge_wait(n);
      `CHK("force_stuck", 300, n)
      wr(ADDR_CTRL, 8'h20);
      lvl_chk(1'b0);
   endtask

   task automatic t_bypass;
      setup(8'h12, 8'h80, 8'h01);
      chip_align <= 1'b0;
      dist_lvl <= 1'b1;
      lvl_chk(1'b1);
      @(posedge mclk);
      dist_lvl <= 1'b0;
      lvl_chk(1'b0);
      @(posedge mclk);
      dist_lvl <= 1'b1;
      lvl_chk(1'b1);
   endtask

   // Offsets 2 and 6 with a tick every cycle must differ by four cycles
   task automatic t_offset;
      int a, b;
      setup(8'h12, 8'h02, 8'h01);
      lvl_chk(1'b0);
      @(posedge mclk);
      chip_align <= 1'b0;
      edge_wait(a);
      setup(8'h12, 8'h06, 8'h01);
      lvl_chk(1'b0);
      @(posedge mclk);
      chip_align <= 1'b0;
      edge_wait(b);
      `CHK("offset_delta", 4, b - a)
   endtask

   task automatic route_chk(input logic [1:0] s, input logic v, input logic e, input logic ex);
      @(posedge mclk);
      src_sel <= s;
      vco_lvl <= v;
      ext_lvl <= e;
      lvl_chk(ex);
   endtask

   // Divider held low so any direct path shows as a high level
   task automatic t_route;
      setup(8'h12, 8'h00, 8'h03);
      route_chk(2'b10, 1'b1, 1'b0, 1'b1);
      route_chk(2'b10, 1'b0, 1'b1, 1'b0);
      route_chk(2'b00, 1'b0, 1'b1, 1'b1);
      route_chk(2'b00, 1'b1, 1'b0, 1'b0);
      route_chk(2'b01, 1'b1, 1'b1, 1'b0);
      route_chk(2'b11, 1'b1, 1'b1, 1'b0);
      rd_chk(ADDR_STATUS, 8'h0C);
      wr(ADDR_ROUTE, 8'h01);
      route_chk(2'b10, 1'b1, 1'b1, 1'b0);
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      n_errors++;
      close_out();
   end

   initial begin
      reset_n = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = '0;
      wdata = '0;
      dist_lvl = 1'b0;
      vco_lvl = 1'b0;
      ext_lvl = 1'b0;
      src_sel = 2'b01;
      chip_align = 1'b1;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_period(8'h01, 3, 2);
      t_period(8'h00, 2, 3);
      t_slow();
      t_sync();
      t_force();
      t_bypass();
      t_offset();
      t_route();
      close_out();
   end
endmodule
`default_nettype wire
